// file: verilog/supervisor_trap_state_csrs.sv
// Supervisor trap state and environment configuration registers with an AXI4-Lite slave.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "sup_trap_defs.svh"
module supervisor_trap_state_csrs #(
  parameter int XLEN = 64,
  parameter int INSN_LEN = 32,
  parameter bit ALIGN_SWITCHABLE = 1'b1,
  parameter bit HAS_TRANSLATION = 1'b1,
  parameter bit REPORT_INSN = 1'b1
) (
  input wire logic i_clk_sys,                       // System clock
  input wire logic i_rst,                           // Synchronous reset, active high
  input wire logic i_trap_valid,                    // Trap into supervisor mode this cycle
  input wire logic i_trap_interrupt,                // Trap is an interrupt
  input wire logic [5:0] i_trap_code,               // Exception or interrupt code
  input wire logic [XLEN-1:0] i_trap_pc,            // Interrupted instruction address
  input wire logic [XLEN-1:0] i_trap_addr,          // Faulting virtual address
  input wire logic [XLEN-1:0] i_trap_insn,          // Faulting instruction bits
  input wire logic i_fence_pred_input,              // User fence predecessor input bit
  input wire logic i_fence_pred_output,             // User fence predecessor output bit
  input wire logic i_fence_succ_input,              // User fence successor input bit
  input wire logic i_fence_succ_output,             // User fence successor output bit
  input wire logic i_amo_io_ordered,                // User atomic to I/O with acquire or release
  input wire logic [31:0] s_axi_awaddr,             // Write address
  input wire logic s_axi_awvalid,                   // Write address valid
  output logic s_axi_awready,                       // Write address ready
  input wire logic [31:0] s_axi_wdata,              // Write data
  input wire logic [3:0] s_axi_wstrb,               // Write strobes
  input wire logic s_axi_wvalid,                    // Write data valid
  output logic s_axi_wready,                        // Write data ready
  output logic [1:0] s_axi_bresp,                   // Write response
  output logic s_axi_bvalid,                        // Write response valid
  input wire logic s_axi_bready,                    // Write response ready
  input wire logic [31:0] s_axi_araddr,             // Read address
  input wire logic s_axi_arvalid,                   // Read address valid
  output logic s_axi_arready,                       // Read address ready
  output logic [31:0] s_axi_rdata,                  // Read data
  output logic [1:0] s_axi_rresp,                   // Read response
  output logic s_axi_rvalid,                        // Read data valid
  input wire logic s_axi_rready,                    // Read data ready
  output logic [XLEN-1:0] o_return_pc,              // Masked exception PC for trap return
  output logic o_pred_memory_read,                  // Widened fence: predecessor memory reads
  output logic o_pred_memory_write,                 // Widened fence: predecessor memory writes
  output logic o_succ_memory_read,                  // Widened fence: successor memory reads
  output logic o_succ_memory_write,                 // Widened fence: successor memory writes
  output logic o_amo_order_memory                   // Atomic also ordered against memory
);
  import sup_trap_pkg::*;

  // ==========================================================================
  // Architectural state.
  logic [XLEN-1:0] supervisor_exception_pc;
  logic cause_interrupt;
  logic [`CAUSE_CODE_W-1:0] cause_code;
  logic [XLEN-1:0] supervisor_trap_value;
  logic io_fence_includes_memory;
  logic align32;
  logic [XLEN-1:0] next_trap_value;
  logic [XLEN-1:0] epc_view;
  logic [XLEN-1:0] cause_view;
  logic [XLEN-1:0] envcfg_view;

  // Bit one is stored but hidden whenever 32-bit alignment is in force.
  always_comb begin
    epc_view = supervisor_exception_pc;
    epc_view[0] = 1'b0;
    if (!ALIGN_SWITCHABLE || align32) begin
      epc_view[1] = 1'b0;
    end
  end

  always_comb begin
    cause_view = '0;
    cause_view[XLEN-1] = cause_interrupt;
    cause_view[`CAUSE_CODE_W-1:0] = cause_code;
    envcfg_view = '0;
    envcfg_view[`IO_FENCE_INCLUDES_MEMORY_BIT] = io_fence_includes_memory;
  end

  trap_value_select #(
    .XLEN(XLEN),
    .INSN_LEN(INSN_LEN),
    .REPORT_INSN(REPORT_INSN)
  ) u_tval (
    .i_interrupt(i_trap_interrupt),
    .i_code(i_trap_code),
    .i_addr(i_trap_addr),
    .i_insn(i_trap_insn),
    .o_value(next_trap_value)
  );

  // ==========================================================================
  // AXI4-Lite write channel.
  wr_state_t wr_state;
  logic aw_held;
  logic w_held;
  logic [5:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_hit;

  assign wr_fire = (wr_state == WR_IDLE) && aw_held && w_held;

  always_comb begin
    case (wr_addr)
      `OFF_EPC_LO, `OFF_EPC_HI, `OFF_CAUSE_LO, `OFF_CAUSE_HI, `OFF_TVAL_LO, `OFF_TVAL_HI,
      `OFF_ENVCFG_LO, `OFF_ENVCFG_HI, `OFF_CTRL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Address and data are latched independently so either may arrive first.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      wr_addr <= 6'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        // An address beyond the register window is parked on an unmapped offset, so it draws an
        // error response instead of aliasing onto a live register.
        if (s_axi_awaddr[31:6] == 26'h0000000) begin
          wr_addr <= {s_axi_awaddr[5:2], 2'b00};
        end else begin
          wr_addr <= `OFF_UNMAPPED;
        end
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end else if (!aw_held && s_axi_awvalid && wr_state == WR_IDLE) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      w_held <= 1'b0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end else if (!w_held && s_axi_wvalid && wr_state == WR_IDLE) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // No new address or data is taken while a response is outstanding, which keeps one write in flight.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      wr_state <= WR_IDLE;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            wr_state <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state <= WR_IDLE;
          end
        end
        default: begin
          wr_state <= WR_IDLE;
        end
      endcase
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Register updates: a trap in the same cycle as a software write wins.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      supervisor_exception_pc <= '0;
    end else if (i_trap_valid) begin
      supervisor_exception_pc <= {i_trap_pc[XLEN-1:1], 1'b0};
    end else if (wr_fire && wr_addr == `OFF_EPC_LO) begin
      supervisor_exception_pc[31:0] <= merge(supervisor_exception_pc[31:0], wr_data, wr_strb) & 32'hFFFFFFFE;
    end else if (wr_fire && wr_addr == `OFF_EPC_HI) begin
      supervisor_exception_pc[XLEN-1:32] <= merge(supervisor_exception_pc[XLEN-1:32], wr_data, wr_strb);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cause_interrupt <= 1'b0;
      cause_code <= '0;
    end else if (i_trap_valid) begin
      cause_interrupt <= i_trap_interrupt;
      cause_code <= i_trap_code;
    end else if (wr_fire && wr_addr == `OFF_CAUSE_LO && wr_strb[0]) begin
      cause_code <= wr_data[`CAUSE_CODE_W-1:0];
    end else if (wr_fire && wr_addr == `OFF_CAUSE_HI && wr_strb[3]) begin
      cause_interrupt <= wr_data[31];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      supervisor_trap_value <= '0;
    end else if (i_trap_valid) begin
      supervisor_trap_value <= next_trap_value;
    end else if (wr_fire && wr_addr == `OFF_TVAL_LO) begin
      supervisor_trap_value[31:0] <= merge(supervisor_trap_value[31:0], wr_data, wr_strb);
    end else if (wr_fire && wr_addr == `OFF_TVAL_HI) begin
      supervisor_trap_value[XLEN-1:32] <= merge(supervisor_trap_value[XLEN-1:32], wr_data, wr_strb);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      io_fence_includes_memory <= 1'b0;
    end else if (wr_fire && wr_addr == `OFF_ENVCFG_LO && wr_strb[0]) begin
      io_fence_includes_memory <= HAS_TRANSLATION ? wr_data[`IO_FENCE_INCLUDES_MEMORY_BIT] : 1'b0;
    end
  end

  // Alignment is a software knob here; it changes only what reads of the exception PC and o_return_pc show.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      align32 <= 1'b0;
    end else if (wr_fire && wr_addr == `OFF_CTRL && wr_strb[0]) begin
      align32 <= wr_data[`CTRL_ALIGN32_BIT];
    end
  end

  // ==========================================================================
  // Fence and atomic ordering widening for user mode.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pred_memory_read <= 1'b0;
      o_pred_memory_write <= 1'b0;
      o_succ_memory_read <= 1'b0;
      o_succ_memory_write <= 1'b0;
      o_amo_order_memory <= 1'b0;
    end else begin
      o_pred_memory_read <= io_fence_includes_memory & i_fence_pred_input;
      o_pred_memory_write <= io_fence_includes_memory & i_fence_pred_output;
      o_succ_memory_read <= io_fence_includes_memory & i_fence_succ_input;
      o_succ_memory_write <= io_fence_includes_memory & i_fence_succ_output;
      o_amo_order_memory <= io_fence_includes_memory & i_amo_io_ordered;
    end
  end

  // The trap-return path reads through the same mask as software, so a hidden bit one never
  // leaks into the return address.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_return_pc <= '0;
    end else begin
      o_return_pc <= epc_view;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel: one read at a time, answered the cycle after acceptance.
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      `OFF_EPC_LO: rd_word = epc_view[31:0];
      `OFF_EPC_HI: rd_word = epc_view[XLEN-1:32];
      `OFF_CAUSE_LO: rd_word = cause_view[31:0];
      `OFF_CAUSE_HI: rd_word = cause_view[XLEN-1:32];
      `OFF_TVAL_LO: rd_word = supervisor_trap_value[31:0];
      `OFF_TVAL_HI: rd_word = supervisor_trap_value[XLEN-1:32];
      `OFF_ENVCFG_LO: rd_word = envcfg_view[31:0];
      `OFF_ENVCFG_HI: rd_word = envcfg_view[XLEN-1:32];
      `OFF_CTRL: rd_word = {31'h00000000, align32};
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
    if (s_axi_araddr[31:6] != 26'h0000000) begin
      rd_hit = 1'b0;
      rd_word = 32'h00000000;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// file: verilog/sup_trap_defs.svh
// Offsets, field positions and codes of the supervisor trap state block.
`ifndef SUP_TRAP_DEFS_SVH
`define SUP_TRAP_DEFS_SVH
// ==========================================================================
// Register byte offsets on the AXI4-Lite slave.
`define OFF_EPC_LO 6'h00
`define OFF_EPC_HI 6'h04
`define OFF_CAUSE_LO 6'h08
`define OFF_CAUSE_HI 6'h0C
`define OFF_TVAL_LO 6'h10
`define OFF_TVAL_HI 6'h14
`define OFF_ENVCFG_LO 6'h18
`define OFF_ENVCFG_HI 6'h1C
`define OFF_CTRL 6'h20
`define OFF_UNMAPPED 6'h3C
// ==========================================================================
// Field positions.
`define CAUSE_CODE_W 6
`define IO_FENCE_INCLUDES_MEMORY_BIT 0
`define CTRL_ALIGN32_BIT 0
// ==========================================================================
// Interrupt codes.
`define IRQ_SUP_SOFT 6'h01
`define IRQ_SUP_TIMER 6'h05
`define IRQ_SUP_EXT 6'h09
// ==========================================================================
// Exception codes.
`define EXC_INSN_MISALIGN 6'h00
`define EXC_INSN_ACCESS 6'h01
`define EXC_ILLEGAL 6'h02
`define EXC_BREAKPOINT 6'h03
`define EXC_LOAD_MISALIGN 6'h04
`define EXC_LOAD_ACCESS 6'h05
`define EXC_STORE_MISALIGN 6'h06
`define EXC_STORE_ACCESS 6'h07
`define EXC_USER_CALL 6'h08
`define EXC_SUP_CALL 6'h09
`define EXC_INSN_PAGE 6'h0C
`define EXC_LOAD_PAGE 6'h0D
`define EXC_STORE_PAGE 6'h0F
// ==========================================================================
// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: verilog/sup_trap_pkg.sv
// Types shared by the supervisor trap state block.
package sup_trap_pkg;
  typedef logic [63:0] xword_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
endpackage

// file: verilog/trap_value_select.sv
// Trap value selection for one trap entry.
`timescale 1ns/100ps
`include "sup_trap_defs.svh"
module trap_value_select #(
  parameter int XLEN = 64,
  parameter int INSN_LEN = 32,
  parameter bit REPORT_INSN = 1'b1
) (
  input wire logic i_interrupt,         // Trap is an interrupt
  input wire logic [5:0] i_code,        // Exception code
  input wire logic [XLEN-1:0] i_addr,   // Faulting portion virtual address
  input wire logic [XLEN-1:0] i_insn,   // Faulting instruction bits, left as fetched
  output logic [XLEN-1:0] o_value       // Value to store
);
  localparam int N = (XLEN < INSN_LEN) ? XLEN : INSN_LEN;
  logic [XLEN-1:0] insn_mask;
  assign insn_mask = (N >= XLEN) ? {XLEN{1'b1}} : ((XLEN'(1) << N) - XLEN'(1));
  always_comb begin
    o_value = '0;
    if (!i_interrupt) begin
      case (i_code)
        `EXC_INSN_MISALIGN, `EXC_INSN_ACCESS, `EXC_BREAKPOINT, `EXC_LOAD_MISALIGN, `EXC_LOAD_ACCESS,
        `EXC_STORE_MISALIGN, `EXC_STORE_ACCESS, `EXC_INSN_PAGE, `EXC_LOAD_PAGE, `EXC_STORE_PAGE: begin
          o_value = i_addr;
        end
        `EXC_ILLEGAL: begin
          o_value = REPORT_INSN ? (i_insn & insn_mask) : '0;
        end
        default: begin
          o_value = '0;
        end
      endcase
    end
  end
endmodule

// file: tb/trap_source.sv
// Behavioural model of the hart trap-entry logic that feeds the block.
`timescale 1ns/100ps
// ==========================================
// Trap source
module trap_source (
  input wire logic i_clk_sys, // Clock
  input wire logic i_fire, // Request one trap
  input wire logic i_int, // Interrupt flag
  input wire logic [5:0] i_code, // Cause code
  input wire logic [63:0] i_pc, // Instruction address
  input wire logic [63:0] i_addr, // Fault address
  input wire logic [63:0] i_insn, // Instruction bits
  output logic o_valid, // One-cycle trap pulse
  output logic o_int, // Interrupt flag
  output logic [5:0] o_code, // Cause code
  output logic [63:0] o_pc, // Instruction address
  output logic [63:0] o_addr, // Fault address
  output logic [63:0] o_insn // Instruction bits
);
  // Between traps the payload is inverted, so the block cannot lean on a stale value.
  always_ff @(posedge i_clk_sys) begin
    o_valid <= i_fire;
    o_int <= i_fire ? i_int : ~o_int;
    o_code <= i_fire ? i_code : ~o_code;
    o_pc <= i_fire ? i_pc : ~o_pc;
    o_addr <= i_fire ? i_addr : ~o_addr;
    o_insn <= i_fire ? i_insn : ~o_insn;
  end
endmodule

// file: tb/supervisor_trap_state_csrs_chk.sv
// Concurrent checks on the ports of the supervisor trap state block.
`timescale 1ns/100ps
// ==========================================
// Checker
module supervisor_trap_state_csrs_chk #(
  parameter int XLEN = 64
) (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_trap_valid, // Trap entry
  input wire logic [XLEN-1:0] i_trap_pc, // Trap address
  input wire logic i_fence_pred_input, // Fence bit
  input wire logic i_fence_pred_output, // Fence bit
  input wire logic i_fence_succ_input, // Fence bit
  input wire logic i_fence_succ_output, // Fence bit
  input wire logic i_amo_io_ordered, // Ordered atomic
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic [XLEN-1:0] o_return_pc, // Return address
  input wire logic o_pred_memory_read, // Widened set
  input wire logic o_pred_memory_write, // Widened set
  input wire logic o_succ_memory_read, // Widened set
  input wire logic o_succ_memory_write, // Widened set
  input wire logic o_amo_order_memory // Widened atomic
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  chk_epc_bit_zero: assert property (o_return_pc[0] == 1'b0)
    else $error("return pc bit zero set");
  chk_trap_loads_pc: assert property (i_trap_valid |=> ##1 o_return_pc[XLEN-1:2] == $past(i_trap_pc[XLEN-1:2], 2))
    else $error("return pc not loaded by trap");
  chk_pc_quiet: assert property ((!i_trap_valid && !s_axi_wvalid) [*3] |=> $stable(o_return_pc))
    else $error("return pc changed without cause");
  chk_pred_read_cause: assert property (o_pred_memory_read |-> $past(i_fence_pred_input))
    else $error("pred read without pred input");
  chk_pred_write_cause: assert property (o_pred_memory_write |-> $past(i_fence_pred_output))
    else $error("pred write without pred output");
  chk_succ_read_hold: assert property ((i_fence_succ_input && o_succ_memory_read && !s_axi_wvalid) [*3] |=> o_succ_memory_read)
    else $error("succ read dropped");
  chk_succ_write_cause: assert property (!$past(i_fence_succ_output) |-> !o_succ_memory_write)
    else $error("succ write without succ output");
  chk_fence_pair: assert property ($past(i_fence_pred_input) && $past(i_fence_succ_output) |-> o_pred_memory_read == o_succ_memory_write)
    else $error("fence widening inconsistent");
  chk_amo_cause: assert property (!$past(i_amo_io_ordered) |-> !o_amo_order_memory)
    else $error("atomic ordered without request");
endmodule

bind supervisor_trap_state_csrs supervisor_trap_state_csrs_chk #(.XLEN(XLEN)) u_supervisor_trap_state_csrs_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_trap_valid(i_trap_valid), .i_trap_pc(i_trap_pc),
  .i_fence_pred_input(i_fence_pred_input), .i_fence_pred_output(i_fence_pred_output),
  .i_fence_succ_input(i_fence_succ_input), .i_fence_succ_output(i_fence_succ_output),
  .i_amo_io_ordered(i_amo_io_ordered), .s_axi_wvalid(s_axi_wvalid), .o_return_pc(o_return_pc),
  .o_pred_memory_read(o_pred_memory_read), .o_pred_memory_write(o_pred_memory_write),
  .o_succ_memory_read(o_succ_memory_read), .o_succ_memory_write(o_succ_memory_write),
  .o_amo_order_memory(o_amo_order_memory));

// file: tb/supervisor_trap_state_csrs_tb.sv
// Self-checking bench for the supervisor trap state block.
`timescale 1ns/100ps
`include "sup_trap_defs.svh"
// ==========================================
// Bench top
module supervisor_trap_state_csrs_tb;
  import sup_trap_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic fire = 1'b0;
  logic f_int = 1'b0;
  logic [5:0] f_code = 6'h00;
  xword_t f_pc = '0, f_addr = '0, f_insn = '0, tp, ta, tn, ret_pc;
  logic tv, ti;
  logic [5:0] tc;
  logic [3:0] fence = 4'h0;
  logic amo = 1'b0;
  logic [4:0] mem_order;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [6:0] tbl [17] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09,
                           7'h0C, 7'h0D, 7'h0F, 7'h1F, 7'h41, 7'h45, 7'h49};
  int n_mismatch = 0;
  int n_checks = 0;
  trap_source u_trap_source (.i_clk_sys(i_clk_sys), .i_fire(fire), .i_int(f_int), .i_code(f_code),
    .i_pc(f_pc), .i_addr(f_addr), .i_insn(f_insn), .o_valid(tv), .o_int(ti), .o_code(tc),
    .o_pc(tp), .o_addr(ta), .o_insn(tn));
  supervisor_trap_state_csrs u_supervisor_trap_state_csrs (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_trap_valid(tv), .i_trap_interrupt(ti), .i_trap_code(tc), .i_trap_pc(tp), .i_trap_addr(ta),
    .i_trap_insn(tn), .i_fence_pred_input(fence[3]), .i_fence_pred_output(fence[2]),
    .i_fence_succ_input(fence[1]), .i_fence_succ_output(fence[0]), .i_amo_io_ordered(amo),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .o_return_pc(ret_pc), .o_pred_memory_read(mem_order[4]),
    .o_pred_memory_write(mem_order[3]), .o_succ_memory_read(mem_order[2]),
    .o_succ_memory_write(mem_order[1]), .o_amo_order_memory(mem_order[0]));
  initial forever #4 i_clk_sys = ~i_clk_sys;
  // ==========================================
  // Tasks
  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  // Both halves of a 64-bit register, low word first.
  task automatic rd64(input logic [31:0] a, output logic [63:0] v);
    logic [1:0] r;
    axi_read(a, v[31:0], r);
    axi_read(a + 32'h4, v[63:32], r);
  endtask
  task automatic trap(input logic k_int, input logic [5:0] k_code, input xword_t pc, a, n);
    @(posedge i_clk_sys);
    fire <= 1'b1;
    f_int <= k_int;
    f_code <= k_code;
    f_pc <= pc;
    f_addr <= a;
    f_insn <= n;
    @(posedge i_clk_sys);
    fire <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  function automatic xword_t exp_tval(input logic [6:0] k, input xword_t a, n);
    if (k[6]) return '0;
    case (k[5:0])
      6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h0C, 6'h0D, 6'h0F: return a;
      6'h02: return {32'h0, n[31:0]};
      default: return '0;
    endcase
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    logic [63:0] v;
    logic [31:0] d;
    logic [1:0] r;
    xword_t pc;
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int a = 0; a <= 32; a += 4) begin
      axi_read(a, d, r);
      check("reset value", d, 64'h0);
    end
    axi_read(32'h24, d, r);
    check("unmapped rresp", r, `RESP_SLVERR);
    axi_write(32'h3C, 32'hFFFF_FFFF, r);
    check("unmapped bresp", r, `RESP_SLVERR);
    axi_write(32'h44, 32'hFFFF_FFFF, r);
    check("window bresp", r, `RESP_SLVERR);
    rd64(`OFF_EPC_LO, v);
    check("epc untouched", v, 64'h0);
    axi_write(`OFF_EPC_LO, 32'hFFFF_FFFF, r);
    axi_write(`OFF_EPC_HI, 32'h1234_5678, r);
    rd64(`OFF_EPC_LO, v);
    check("epc", v, 64'h1234_5678_FFFF_FFFE);
    axi_write(`OFF_CTRL, 32'h0000_0001, r);
    rd64(`OFF_EPC_LO, v);
    check("epc align32", v, 64'h1234_5678_FFFF_FFFC);
    check("return pc align32", ret_pc, 64'h1234_5678_FFFF_FFFC);
    axi_write(`OFF_CTRL, 32'h0000_0000, r);
    rd64(`OFF_EPC_LO, v);
    check("epc align16", v, 64'h1234_5678_FFFF_FFFE);
    for (int i = 0; i < 17; i++) begin
      pc = 64'h0000_0040_0000_1003 + 64'(i * 16);
      trap(tbl[i][6], tbl[i][5:0], pc, 64'hFFFF_FFC0_0000_0101 + 64'(i), 64'hDEAD_BEEF_0000_0013 + 64'(i));
      rd64(`OFF_EPC_LO, v);
      check("epc", v, pc & ~64'h1);
      check("return pc", ret_pc, pc & ~64'h1);
      rd64(`OFF_CAUSE_LO, v);
      check("cause", v, {tbl[i][6], 57'h0, tbl[i][5:0]});
      rd64(`OFF_TVAL_LO, v);
      check("tval", v, exp_tval(tbl[i], 64'hFFFF_FFC0_0000_0101 + 64'(i), 64'hDEAD_BEEF_0000_0013 + 64'(i)));
    end
    axi_write(`OFF_TVAL_LO, 32'hA5A5_A5A5, r);
    rd64(`OFF_TVAL_LO, v);
    check("tval written", v, 64'h0000_0000_A5A5_A5A5);
    axi_write(`OFF_CAUSE_LO, 32'h0000_0003, r);
    rd64(`OFF_CAUSE_LO, v);
    check("cause written", v, 64'h8000_0000_0000_0003);
    axi_write(`OFF_ENVCFG_LO, 32'hFFFF_FFFF, r);
    axi_write(`OFF_ENVCFG_HI, 32'hFFFF_FFFF, r);
    rd64(`OFF_ENVCFG_LO, v);
    check("envcfg", v, 64'h1);
    fence <= 4'hF;
    amo <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    check("widened all", mem_order, 5'h1F);
    fence <= 4'hA;
    amo <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    check("widened inputs", mem_order, 5'h14);
    amo <= 1'b1;
    axi_write(`OFF_ENVCFG_LO, 32'h0000_0000, r);
    repeat (3) @(posedge i_clk_sys);
    check("widening off", mem_order, 5'h00);
    finish_test();
  end
endmodule
